/* logic/blit_pkg.sv */
// shared constants, field positions and engine states of the block-transfer engine
package blit_pkg;
  localparam int IO_ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 21;
  localparam int CNT_W = 12;
  localparam int CTRL_W = 20;
  localparam int QUEUE_AW = 4;

  // register word offsets; the low two address bits are ignored, byte enables pick the half of a word
  localparam logic [15:0] OFS_BG_COLOUR = 16'h8bd0;
  localparam logic [15:0] OFS_FG_COLOUR = 16'h8fd0;
  localparam logic [15:0] OFS_CONTROL_STATUS = 16'h93d0;
  localparam logic [15:0] OFS_SOURCE_ADDRESS = 16'h97d0;
  localparam logic [15:0] OFS_DEST_ADDRESS = 16'h9bd0;
  localparam logic [15:0] OFS_BLOCK_SIZE_CMD = 16'h9fd0;
  localparam logic [15:0] OFS_HOST_DATA = 16'hbfd0;

  // control word fields
  localparam int ROP_LSB = 0;
  localparam int BIT_INC_Y = 8;
  localparam int BIT_INC_X = 9;
  localparam int BIT_SRC_FG = 10;
  localparam int BIT_SRC_MONO = 11;
  localparam int BIT_PAT_MONO = 12;
  localparam int BIT_BG_TRANSP = 13;
  localparam int SRC_SEL_LSB = 14;
  localparam int SEED_LSB = 16;
  localparam int BIT_SOLID = 19;
  localparam int BIT_BUSY = 20;
  localparam int FREE_LSB = 24;
  localparam int LINES_LSB = 16;

  localparam logic [1:0] SRC_SEL_SCREEN = 2'h0;
  localparam logic [1:0] SRC_SEL_SYSTEM = 2'h1;

  // queue of host source doublewords
  localparam logic [3:0] QUEUE_DEPTH = 4'hf;

  // reset values
  localparam logic [15:0] RST_COLOUR = 16'h0000;
  localparam logic [CTRL_W-1:0] RST_CONTROL = 20'h00000;
  localparam logic [ADDR_W-1:0] RST_ADDRESS = 21'h000000;
  localparam logic [CNT_W-1:0] RST_COUNT = 12'h000;

  typedef enum logic [3:0] {
    S_IDLE, S_SRC, S_SRC_W, S_PAT, S_PAT_W, S_DST, S_DST_W, S_WR, S_WR_W, S_STEP
  } eng_state_t;
endpackage

/* logic/blit_rop_unit.sv */
// three-operand raster operation, one table lookup per data bit
`timescale 1ns/1ps
module blit_rop_unit #(
  parameter int W = 8
) (
  input wire logic [7:0] raster_operation_code,
  input wire logic [W-1:0] src,
  input wire logic [W-1:0] pat,
  input wire logic [W-1:0] dst,
  output logic [W-1:0] result
);
  // index order is pattern, source, destination, so every one of the 256 functions is reachable
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign result[i] = raster_operation_code[{pat[i], src[i], dst[i]}];
  end
endmodule

/* logic/blit_queue_mem.sv */
// storage for host source doublewords, registered read
`timescale 1ns/1ps
module blit_queue_mem #(
  parameter int W = 32,
  parameter int D = 15,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read-before-write: a word written this cycle shows one cycle later
  always_ff @(posedge clk_sys) begin
    rdata <= mem[raddr];
  end
endmodule

/* logic/blit_engine_control_regs.sv */
// block-transfer engine: colour, control, address and size registers plus the drawing sequencer
`timescale 1ns/1ps
module blit_engine_control_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [blit_pkg::IO_ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_be,
  input wire logic [blit_pkg::DATA_W-1:0] io_wdata,
  output logic [blit_pkg::DATA_W-1:0] io_rdata,
  output logic io_rvalid,
  input wire logic pix_16bpp,
  input wire logic [blit_pkg::CNT_W-1:0] src_line_offset,
  input wire logic [blit_pkg::CNT_W-1:0] dst_line_offset,
  input wire logic [blit_pkg::ADDR_W-1:0] pattern_pointer,
  output logic mem_req,
  output logic mem_we,
  output logic [blit_pkg::ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic busy
);
  import blit_pkg::*;

  logic [15:0] bg_colour;
  logic [15:0] fg_colour;
  logic [CTRL_W-1:0] ctrl;
  logic [ADDR_W-1:0] src_addr;
  logic [ADDR_W-1:0] dst_addr;
  logic [CNT_W-1:0] cmd_bytes;
  logic [CNT_W-1:0] cmd_lines;
  eng_state_t state;
  logic [CNT_W-1:0] xcnt;
  logic [CNT_W-1:0] lines_left;
  logic [ADDR_W-1:0] line_src;
  logic [ADDR_W-1:0] line_dst;
  logic [ADDR_W-1:0] src_cur;
  logic [ADDR_W-1:0] dst_cur;
  logic [2:0] pat_row;
  logic [7:0] src_q;
  logic [7:0] pat_q;
  logic [7:0] dst_q;
  logic [1:0] sys_lane;
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [3:0] q_count;
  logic head_ok;
  logic [DATA_W-1:0] q_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    return (p == QUEUE_DEPTH - 4'h1) ? 4'h0 : p + 4'h1;
  endfunction

  // register decode works on the word address; halves are chosen by byte enables
  logic [13:0] word;
  assign word = io_addr[15:2];
  logic hit_bg, hit_fg, hit_ctrl, hit_src, hit_dst, hit_cmd, hit_data;
  assign hit_bg = word == OFS_BG_COLOUR[15:2];
  assign hit_fg = word == OFS_FG_COLOUR[15:2];
  assign hit_ctrl = word == OFS_CONTROL_STATUS[15:2];
  assign hit_src = word == OFS_SOURCE_ADDRESS[15:2];
  assign hit_dst = word == OFS_DEST_ADDRESS[15:2];
  assign hit_cmd = word == OFS_BLOCK_SIZE_CMD[15:2];
  assign hit_data = word == OFS_HOST_DATA[15:2];

  logic [31:0] cmd_word;
  logic [31:0] cmd_merged;
  logic start;
  assign cmd_word = {4'h0, cmd_lines, 4'h0, cmd_bytes};
  assign cmd_merged = merge(cmd_word, io_wdata, io_be);
  // the write that carries the top lane completes the size and launches the engine if it is idle and both counts are non-zero
  assign start = io_wr && hit_cmd && io_be[3] && state == S_IDLE && cmd_merged[LINES_LSB +: CNT_W] != RST_COUNT
                 && cmd_merged[CNT_W-1:0] != RST_COUNT;

  logic [3:0] free;
  assign free = QUEUE_DEPTH - q_count;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bg_colour <= RST_COLOUR;
      fg_colour <= RST_COLOUR;
      ctrl <= RST_CONTROL;
      src_addr <= RST_ADDRESS;
      dst_addr <= RST_ADDRESS;
      cmd_bytes <= RST_COUNT;
      cmd_lines <= RST_COUNT;
    end else if (io_wr) begin
      // only the low half of a colour is stored; the upper half is a readback copy
      if (hit_bg) bg_colour <= 16'(merge({16'h0000, bg_colour}, io_wdata, io_be));
      if (hit_fg) fg_colour <= 16'(merge({16'h0000, fg_colour}, io_wdata, io_be));
      if (hit_ctrl) ctrl <= CTRL_W'(merge({12'h000, ctrl}, io_wdata, io_be));
      if (hit_src) src_addr <= ADDR_W'(merge({11'h000, src_addr}, io_wdata, io_be));
      if (hit_dst) dst_addr <= ADDR_W'(merge({11'h000, dst_addr}, io_wdata, io_be));
      if (hit_cmd) begin
        cmd_bytes <= cmd_merged[CNT_W-1:0];
        cmd_lines <= cmd_merged[LINES_LSB +: CNT_W];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 32'h0000_0000;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        if (hit_bg) io_rdata <= {bg_colour, bg_colour};
        else if (hit_fg) io_rdata <= {fg_colour, fg_colour};
        else if (hit_ctrl) io_rdata <= {4'h0, free, 3'h0, busy, ctrl};
        else if (hit_src) io_rdata <= {11'h000, src_addr};
        else if (hit_dst) io_rdata <= {11'h000, dst_addr};
        else if (hit_cmd) io_rdata <= cmd_word;
        else io_rdata <= 32'h0000_0000;
      end
    end
  end

  // operand selection
  logic [1:0] src_sel;
  logic src_fg, src_mono, pat_mono, solid, transp, src_sys, mono_new, src_new;
  assign src_sel = ctrl[SRC_SEL_LSB +: 2];
  assign src_fg = ctrl[BIT_SRC_FG];
  assign src_mono = ctrl[BIT_SRC_MONO];
  assign pat_mono = ctrl[BIT_PAT_MONO];
  assign solid = ctrl[BIT_SOLID];
  assign transp = ctrl[BIT_BG_TRANSP];
  assign src_sys = src_sel == SRC_SEL_SYSTEM;
  assign mono_new = pix_16bpp ? xcnt[3:0] == 4'h0 : xcnt[2:0] == 3'h0;
  assign src_new = !src_mono || mono_new;

  logic [7:0] fg_lane, bg_lane;
  logic [2:0] src_bit_idx, pat_bit_idx;
  logic sbit, pbit;
  assign fg_lane = dst_cur[0] ? fg_colour[15:8] : fg_colour[7:0];
  assign bg_lane = dst_cur[0] ? bg_colour[15:8] : bg_colour[7:0];
  assign src_bit_idx = pix_16bpp ? xcnt[3:1] : xcnt[2:0];
  assign pat_bit_idx = pix_16bpp ? dst_cur[3:1] : dst_cur[2:0];
  assign sbit = src_q[3'h7 - src_bit_idx];
  assign pbit = pat_q[3'h7 - pat_bit_idx];

  logic [7:0] src_byte, pat_byte, rop_out;
  logic skip;
  always_comb begin
    if (src_fg) src_byte = fg_lane;
    else if (src_mono) src_byte = sbit ? fg_lane : bg_lane;
    else src_byte = src_q;
    if (solid) pat_byte = fg_lane;
    else if (pat_mono) pat_byte = pbit ? fg_lane : bg_lane;
    else pat_byte = pat_q;
  end
  assign skip = transp && ((src_mono && !src_fg && !sbit) || (!solid && pat_mono && !pbit));

  blit_rop_unit #(.W(8)) u_rop (
    .raster_operation_code(ctrl[ROP_LSB +: 8]),
    .src(src_byte),
    .pat(pat_byte),
    .dst(dst_q),
    .result(rop_out)
  );

  // pattern fetch address: low pointer bits replaced by row, and by pixel position unless the pattern is monochrome
  logic [ADDR_W-1:0] pat_addr;
  always_comb begin
    if (pat_mono) pat_addr = {pattern_pointer[20:3], pat_row};
    else if (pix_16bpp) pat_addr = {pattern_pointer[20:7], pat_row, dst_cur[3:0]};
    else pat_addr = {pattern_pointer[20:6], pat_row, dst_cur[2:0]};
  end

  logic [ADDR_W-1:0] mono_src_addr;
  assign mono_src_addr = line_src + (pix_16bpp ? {13'h0000, xcnt[11:4]} : {12'h000, xcnt[11:3]});

  logic take, qpop, push, eol;
  assign take = state == S_SRC && !src_fg && src_sys && src_new && head_ok;
  assign qpop = take && sys_lane == 2'h3;
  // a full queue drops the word; software polls the free count first
  assign push = io_wr && hit_data && q_count != QUEUE_DEPTH;
  assign eol = xcnt + 12'h001 == cmd_bytes;

  logic [ADDR_W-1:0] next_line_src, next_line_dst;
  assign next_line_src = line_src + {9'h000, src_line_offset};
  assign next_line_dst = line_dst + {9'h000, dst_line_offset};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      q_count <= 4'h0;
      head_ok <= 1'b0;
    end else begin
      if (push) wr_ptr <= ptr_inc(wr_ptr);
      if (qpop) rd_ptr <= ptr_inc(rd_ptr);
      q_count <= q_count + {3'h0, push} - {3'h0, qpop};
      // a word written into an empty queue becomes readable one cycle late
      head_ok <= q_count > {3'h0, qpop};
    end
  end

  blit_queue_mem #(.W(DATA_W), .D(15), .AW(QUEUE_AW)) u_queue (
    .clk_sys(clk_sys),
    .we(push),
    .waddr(wr_ptr),
    .wdata(io_wdata),
    .raddr(qpop ? ptr_inc(rd_ptr) : rd_ptr),
    .rdata(q_rdata)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_IDLE;
      busy <= 1'b0;
      xcnt <= RST_COUNT;
      lines_left <= RST_COUNT;
      line_src <= RST_ADDRESS;
      line_dst <= RST_ADDRESS;
      src_cur <= RST_ADDRESS;
      dst_cur <= RST_ADDRESS;
      pat_row <= 3'h0;
      src_q <= 8'h00;
      pat_q <= 8'h00;
      dst_q <= 8'h00;
      sys_lane <= 2'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= RST_ADDRESS;
      mem_wdata <= 8'h00;
    end else begin
      unique case (state)
        S_IDLE: if (start) begin
          busy <= 1'b1;
          line_src <= src_addr;
          src_cur <= src_addr;
          line_dst <= dst_addr;
          dst_cur <= dst_addr;
          xcnt <= RST_COUNT;
          lines_left <= cmd_merged[LINES_LSB +: CNT_W];
          pat_row <= ctrl[SEED_LSB +: 3];
          sys_lane <= 2'h0;
          state <= S_SRC;
        end
        S_SRC: begin
          if (!src_fg && src_new && src_sys) begin
            if (head_ok) begin
              src_q <= q_rdata[sys_lane*8 +: 8];
              sys_lane <= sys_lane + 2'h1;
              state <= S_PAT;
            end
          end else if (!src_fg && src_new) begin
            mem_req <= 1'b1;
            mem_addr <= src_mono ? mono_src_addr : src_cur;
            state <= S_SRC_W;
          end else begin
            state <= S_PAT;
          end
        end
        S_SRC_W: if (mem_ack) begin
          mem_req <= 1'b0;
          src_q <= mem_rdata;
          state <= S_PAT;
        end
        S_PAT: if (!solid) begin
          mem_req <= 1'b1;
          mem_addr <= pat_addr;
          state <= S_PAT_W;
        end else begin
          state <= S_DST;
        end
        S_PAT_W: if (mem_ack) begin
          mem_req <= 1'b0;
          pat_q <= mem_rdata;
          state <= S_DST;
        end
        S_DST: if (skip) begin
          state <= S_STEP;
        end else begin
          mem_req <= 1'b1;
          mem_addr <= dst_cur;
          state <= S_DST_W;
        end
        S_DST_W: if (mem_ack) begin
          mem_req <= 1'b0;
          dst_q <= mem_rdata;
          state <= S_WR;
        end
        S_WR: begin
          mem_req <= 1'b1;
          mem_we <= 1'b1;
          mem_addr <= dst_cur;
          mem_wdata <= rop_out;
          state <= S_WR_W;
        end
        S_WR_W: if (mem_ack) begin
          mem_req <= 1'b0;
          mem_we <= 1'b0;
          state <= S_STEP;
        end
        S_STEP: begin
          state <= S_SRC;
          if (!eol) begin
            xcnt <= xcnt + 12'h001;
            src_cur <= ctrl[BIT_INC_X] ? src_cur + 21'h000001 : src_cur - 21'h000001;
            dst_cur <= ctrl[BIT_INC_X] ? dst_cur + 21'h000001 : dst_cur - 21'h000001;
          end else if (lines_left == 12'h001) begin
            busy <= 1'b0;
            state <= S_IDLE;
          end else begin
            xcnt <= RST_COUNT;
            lines_left <= lines_left - 12'h001;
            line_src <= next_line_src;
            line_dst <= next_line_dst;
            src_cur <= next_line_src;
            dst_cur <= next_line_dst;
            pat_row <= ctrl[BIT_INC_Y] ? pat_row + 3'h1 : pat_row - 3'h1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_cmd_start;
    start;
  endsequence
  sequence s_mid_step;
    state == S_STEP && !eol;
  endsequence
  sequence s_next_line;
    state == S_STEP && eol && lines_left != 12'h001;
  endsequence

  a_busy_start: assert property (s_cmd_start |=> busy && state == S_SRC) else $error("busy not set on command");
  a_seed_row: assert property (s_cmd_start |=> pat_row == $past(ctrl[SEED_LSB +: 3])) else $error("seed row wrong");
  a_busy_read: assert property (io_rd && hit_ctrl |=> io_rvalid && io_rdata[BIT_BUSY] == $past(busy))
    else $error("status bit does not follow engine");
  a_colour_dup: assert property (io_rd && (hit_bg || hit_fg) |=> io_rdata[31:16] == io_rdata[15:0])
    else $error("colour readback not duplicated");
  a_free_level: assert property (push && !qpop |=> free == $past(free) - 4'h1) else $error("free count wrong");
  a_dest_only: assert property (mem_req && mem_we |-> mem_addr == dst_cur) else $error("write off destination");
  a_x_step: assert property (s_mid_step |=> dst_cur == ($past(ctrl[BIT_INC_X]) ? $past(dst_cur) + 21'h000001 :
    $past(dst_cur) - 21'h000001)) else $error("pixel step direction wrong");
  a_line_step: assert property (s_next_line |=> line_dst == $past(line_dst) + {9'h000, $past(dst_line_offset)}
    && pat_row == ($past(ctrl[BIT_INC_Y]) ? $past(pat_row) + 3'h1 : $past(pat_row) - 3'h1))
    else $error("line step wrong");
  a_pat_align: assert property (state == S_PAT_W && pat_mono |-> mem_addr[20:3] == pattern_pointer[20:3])
    else $error("pattern fetch not aligned");
  a_transp_skip: assert property (state == S_DST && skip |=> state == S_STEP ##1 !mem_we)
    else $error("transparent pixel written");
  a_bg_expand: assert property (state == S_DST && src_mono && !src_fg && !sbit |-> src_byte == bg_lane)
    else $error("background colour not used");
endmodule

/* tb/blit_partner.sv */
// host bus model and display memory model that face the block-transfer engine
`timescale 1ns/1ps
module blit_host_model (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic [blit_pkg::DATA_W-1:0] io_rdata,
  input wire logic io_rvalid,
  output logic [blit_pkg::IO_ADDR_W-1:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [3:0] io_be,
  output logic [blit_pkg::DATA_W-1:0] io_wdata
);
  import blit_pkg::*;
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_be = 4'h0;
    io_wdata = 32'h00000000;
  end
  // strobe stands for exactly the take edge; data is scrambled once released
  task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_be <= be;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_wdata <= ~d;
  endtask
  // read data is only trusted while io_rvalid is high
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    // look while the answer stands, away from the edge that retires it
    @(negedge clk_sys);
    d = io_rvalid ? io_rdata : 32'hxxxxxxxx;
  endtask
  // colours are replicated into every lane, all 16 bits when wide, else only the low byte
  task automatic colour(input logic [15:0] a, input logic [15:0] c, input logic wide);
    wr(a, 4'hf, wide ? {c, c} : {4{c[7:0]}});
  endtask
  // nothing is written and no address is read back until the engine is idle or 4000 cycles have passed
  task automatic wait_idle(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 4000 && !ok; i++) begin
      @(posedge clk_sys);
      ok = (busy === 1'b0);
    end
  endtask
endmodule

module blit_mem_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [blit_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [3:0] slow,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  import blit_pkg::*;
  logic [7:0] store [int];
  logic [28:0] wr_q [$];
  logic [3:0] wait_cnt;
  logic acked;
  // unwritten bytes read as a fixed function of their address
  function automatic logic [7:0] fetch(input logic [ADDR_W-1:0] a);
    return store.exists(a) ? store[a] : a[7:0] ^ 8'h3c;
  endfunction
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      wait_cnt <= 4'h0;
      acked <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      // data lane toggles outside the ack so a stale sample never matches
      mem_rdata <= ~mem_rdata;
      if (!mem_req) begin
        acked <= 1'b0;
        wait_cnt <= 4'h0;
      end else if (!acked && wait_cnt < slow) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else if (!acked) begin
        mem_ack <= 1'b1;
        acked <= 1'b1;
        if (mem_we) begin
          store[mem_addr] = mem_wdata;
          wr_q.push_back({mem_addr, mem_wdata});
        end else begin
          mem_rdata <= fetch(mem_addr);
        end
      end
    end
  end
endmodule

/* tb/test_blit_engine_control_regs.sv */
// self-checking bench for the block-transfer engine registers and sequencer
`timescale 1ns/1ps
`define check(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("BAD %0t got %h expected %h", $time, got, exp); end end
module test_blit_engine_control_regs;
  import blit_pkg::*;
  logic clk_sys, sys_rst, io_wr, io_rd, io_rvalid, pix_16bpp, mem_req, mem_we, mem_ack, busy;
  logic [15:0] io_addr;
  logic [3:0] io_be, slow;
  logic [31:0] io_wdata, io_rdata;
  logic [11:0] src_line_offset, dst_line_offset;
  logic [20:0] pattern_pointer, mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  int error_cnt, cmp_count;

  blit_engine_control_regs u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_be(io_be), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .pix_16bpp(pix_16bpp), .src_line_offset(src_line_offset), .dst_line_offset(dst_line_offset),
    .pattern_pointer(pattern_pointer), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
  blit_host_model u_host (.clk_sys(clk_sys), .busy(busy), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_be(io_be), .io_wdata(io_wdata));
  blit_mem_model u_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_host.rd(a, d);
    `check(d, exp)
  endtask

  task automatic t_reset_values();
    rd_chk(OFS_BG_COLOUR, 32'h00000000);
    rd_chk(OFS_FG_COLOUR, 32'h00000000);
    rd_chk(OFS_CONTROL_STATUS, 32'h0f000000);
    rd_chk(OFS_SOURCE_ADDRESS, 32'h00000000);
    rd_chk(OFS_DEST_ADDRESS, 32'h00000000);
    rd_chk(OFS_BLOCK_SIZE_CMD, 32'h00000000);
  endtask

  task automatic t_fields();
    u_host.wr(OFS_BG_COLOUR, 4'h3, 32'hffff5a3c);
    rd_chk(OFS_BG_COLOUR, 32'h5a3c5a3c);
    u_host.colour(OFS_FG_COLOUR, 16'ha55a, 1'b1);
    rd_chk(OFS_FG_COLOUR, 32'ha55aa55a);
    u_host.wr(OFS_CONTROL_STATUS, 4'hf, 32'hffffffff);
    rd_chk(OFS_CONTROL_STATUS, 32'h0f0fffff);
    u_host.wr(OFS_SOURCE_ADDRESS, 4'hf, 32'hffffffff);
    rd_chk(OFS_SOURCE_ADDRESS, 32'h001fffff);
    u_host.wr(OFS_DEST_ADDRESS, 4'hf, 32'hffffffff);
    rd_chk(OFS_DEST_ADDRESS, 32'h001fffff);
    u_host.wr(OFS_BLOCK_SIZE_CMD, 4'h3, 32'hffffffff);
    rd_chk(OFS_BLOCK_SIZE_CMD, 32'h00000fff);
    u_host.wr(OFS_BLOCK_SIZE_CMD, 4'hf, 32'h00000000);
    @(negedge clk_sys);
    `check(busy, 1'b0)
    rd_chk(16'h1000, 32'h00000000);
  endtask

  // starts a transfer, reads the status word once, then waits on busy until the engine is idle again
  task automatic run_blit(input logic [31:0] ctrl, input logic [31:0] size);
    logic [31:0] d;
    logic ok;
    u_mem.wr_q.delete();
    u_host.wr(OFS_CONTROL_STATUS, 4'hf, ctrl);
    u_host.wr(OFS_BLOCK_SIZE_CMD, 4'hf, size);
    @(negedge clk_sys);
    `check(busy, 1'b1)
    u_host.rd(OFS_CONTROL_STATUS, d);
    `check(d, {12'h0f1, ctrl[19:0]})
    u_host.wait_idle(ok);
    `check(ok, 1'b1)
  endtask

  // xr selects source-xor-destination data, otherwise the foreground lane of each byte
  task automatic expect_writes(input int dst, input int src, input int soff, input int doff, input int n,
    input int lines, input bit inc, input bit xr);
    int k;
    int d;
    int s;
    logic [7:0] v;
    k = 0;
    `check(u_mem.wr_q.size(), n * lines)
    for (int l = 0; l < lines; l++) begin
      for (int i = 0; i < n; i++) begin
        d = dst + l * doff + (inc ? i : -i);
        s = src + l * soff + (inc ? i : -i);
        v = xr ? (s[7:0] ^ d[7:0]) : (d[0] ? 8'ha5 : 8'h5a);
        if (k < u_mem.wr_q.size()) `check(u_mem.wr_q[k], {d[20:0], v})
        k++;
      end
    end
  endtask

  task automatic t_solid_fill();
    u_host.wr(OFS_DEST_ADDRESS, 4'hf, 32'h00000100);
    @(posedge clk_sys);
    dst_line_offset <= 12'h020;
    run_blit(32'h000807cc, 32'h00020003);
    expect_writes(32'h100, 0, 0, 32'h20, 3, 2, 1'b1, 1'b0);
  endtask

  // monochrome pattern byte 3c at row 0: only pixels 2..5 of the line carry set bits
  task automatic t_transparent_pattern();
    u_host.wr(OFS_DEST_ADDRESS, 4'hf, 32'h00000300);
    run_blit(32'h000037f0, 32'h00010008);
    expect_writes(32'h302, 0, 0, 0, 4, 1, 1'b1, 1'b0);
  endtask

  task automatic t_xor_leftward();
    u_host.wr(OFS_SOURCE_ADDRESS, 4'hf, 32'h00000040);
    u_host.wr(OFS_DEST_ADDRESS, 4'hf, 32'h00000200);
    @(posedge clk_sys);
    src_line_offset <= 12'h010;
    dst_line_offset <= 12'h030;
    slow <= 4'h3;
    run_blit(32'h00080166, 32'h00020002);
    expect_writes(32'h200, 32'h40, 32'h10, 32'h30, 2, 2, 1'b0, 1'b1);
  endtask

  task automatic t_queue_free();
    u_host.wr(OFS_HOST_DATA, 4'hf, 32'h01020304);
    u_host.wr(OFS_HOST_DATA, 4'hf, 32'h05060708);
    rd_chk(OFS_CONTROL_STATUS, 32'h0d080166);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // the whole run needs well under 5000 cycles
  initial begin
    #200000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    pix_16bpp = 1'b0;
    src_line_offset = 12'h000;
    dst_line_offset = 12'h000;
    pattern_pointer = 21'h000000;
    slow = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_values();
    t_fields();
    t_solid_fill();
    t_transparent_pattern();
    t_xor_leftward();
    t_queue_free();
    conclude();
  end
endmodule
